/* File: src/mse_pkg.sv */
// Purpose: shared constants for the extended mode-sense responder
// Assumes: 50 MHz clk, APB register access, one page layout for all pages
// Notes:   page order in PAGE_CODE is the all-pages return order
// Functional notes
// - opcode 5Ah selects extended mode sense
// - selector 00b returns current operating values
// - current equals saved until a select completes
// - selector 01b returns changeable-bit mask
// - selector 10b returns factory default values
// - selector 11b returns saved, else default values
// - page length byte gives supported parameter count
// - decode twelve supported six-bit page codes
// - code 3Fh returns all pages, 00h last
// - stop after minimum of allocation and available
// - header, one descriptor, then mode pages
// - mode data length first, excludes itself
// - medium type, reserved bytes, protect flag zero
// - block descriptor length reads 0008h
// - descriptor bytes 0,4 zero; 24-bit block count
// - descriptor bytes 5-7 hold block length
// - page byte0 savable flag, zero, page code
// - savable flag one means page can be saved; the save copy ignores the flag and copies every committed page
// - save flag copies current table into saved
package mse_pkg;
	localparam logic [7:0]  OPCODE_SENSE_EXT = 8'h5a;
	localparam logic [5:0]  CODE_ALL_PAGES   = 6'h3f;
	localparam int          PAGE_COUNT       = 12;
	localparam logic [5:0]  PAGE_CODE [0:11] = '{6'h01, 6'h02, 6'h03,
		6'h04, 6'h08, 6'h0a, 6'h0c, 6'h32, 6'h37, 6'h38, 6'h39, 6'h00};
	// page body: code byte, length byte, six parameter bytes
	localparam logic [7:0]  PAGE_PARAM_LEN   = 8'h06;
	localparam logic [6:0]  HDR_DESC_LEN     = 7'h10;
	localparam logic [6:0]  RESP_ONE_LEN     = 7'h18;
	localparam logic [6:0]  RESP_ALL_LEN     = 7'h70;
	localparam logic [7:0]  DESC_LEN         = 8'h08;
	// page value selector encodings
	localparam logic [1:0]  SEL_CURRENT      = 2'h0;
	localparam logic [1:0]  SEL_CHANGEABLE   = 2'h1;
	localparam logic [1:0]  SEL_DEFAULT      = 2'h2;
	localparam logic [1:0]  SEL_SAVED        = 2'h3;
	// table numbers inside the parameter memory
	localparam logic [1:0]  TBL_CUR          = 2'h0;
	localparam logic [1:0]  TBL_CHG          = 2'h1;
	localparam logic [1:0]  TBL_DEF          = 2'h2;
	localparam logic [1:0]  TBL_SAV          = 2'h3;
	localparam int          TBL_DEPTH        = 512;
	localparam logic [6:0]  COPY_LAST        = 7'h5f;
	// apb register offsets
	localparam logic [7:0]  OFS_CTRL         = 8'h00;
	localparam logic [7:0]  OFS_STATUS       = 8'h04;
	localparam logic [7:0]  OFS_MEMWR        = 8'h08;
	localparam logic [7:0]  OFS_SAVABLE      = 8'h0c;
	localparam logic [7:0]  OFS_BLKCNT       = 8'h10;
	localparam logic [7:0]  OFS_BLKLEN       = 8'h14;
	// field positions
	localparam int          CTRL_COMMIT_BIT  = 0;
	localparam int          CTRL_SAVE_BIT    = 1;
	localparam int          MW_BYTE_LSB      = 8;
	localparam int          MW_PAGE_LSB      = 12;
	localparam int          MW_TBL_LSB       = 16;
	// reset values
	localparam logic [11:0] RST_SAVABLE      = 12'hfff;
	localparam logic [23:0] RST_BLKCNT       = 24'h000000;
	localparam logic [23:0] RST_BLKLEN       = 24'h000200;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_CHECK  = 3'b001,
		ST_FETCH  = 3'b010,
		ST_LOAD   = 3'b011,
		ST_SEND   = 3'b100,
		ST_FINISH = 3'b101
	} state_t;
endpackage : mse_pkg

/* File: src/mem_if.sv */
// Purpose: carries the parameter memory port between the two design modules
// Assumes: one writer and one reader, both on the block clock
// Notes:   read data lags the read address by one clock
`timescale 1ns/1ns
// bundle between the responder and its parameter memory
interface mem_if;
	logic [8:0] rdAddr;
	logic [7:0] rdData;
	logic       wrEn;
	logic [8:0] wrAddr;
	logic [7:0] wrData;
	modport ctrl (output rdAddr, wrEn, wrAddr, wrData, input rdData);
	modport mem  (input rdAddr, wrEn, wrAddr, wrData, output rdData);
endinterface : mem_if

/* File: src/param_table_ram.sv */
// Purpose: four parameter tables, twelve pages of eight slots each
// Assumes: address is {table, page index, parameter byte}
// Notes:   read data is registered, one cycle after the address
`timescale 1ns/1ns
module param_table_ram import mse_pkg::*; (
	// clock
	input wire logic clk,
	// table port
	mem_if.mem       port
);
	logic [7:0] store [0:TBL_DEPTH-1];

	// no reset: contents are loaded by software before use
	always_ff @(posedge clk) begin
		if (port.wrEn) begin
			store[port.wrAddr] <= port.wrData;
		end
		port.rdData <= store[port.rdAddr];
	end
endmodule : param_table_ram

/* File: src/mode_sense_ext_responder.sv */
// Purpose: answers the extended mode-sense command block
// Assumes: command block comes from bus-phase logic, data bytes go back to it
// Notes:   one byte every three clocks at most; pages are 8 bytes
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ns
module mode_sense_ext_responder import mse_pkg::*; (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// command block, byte 0 in bits 79:72
	input  wire logic        cdbValid,
	input  wire logic [79:0] cdb,
	output logic             cdbReady,
	// data-in byte stream
	output logic      [7:0]  dataByte,
	output logic             dataValid,
	input  wire logic        dataReady,
	// completion
	output logic             cmdDone,
	output logic             cmdCheck
);
	mem_if tbl ();

	param_table_ram ram (
		.clk  (clk),
		.port (tbl.mem)
	);

	// table that answers a selector, given which pages were replaced
	function automatic logic [1:0] tableFor(input logic [1:0] sel,
		input logic curOwn, input logic savOwn);
		unique case (sel)
			SEL_CURRENT:    tableFor = curOwn ? TBL_CUR :
				(savOwn ? TBL_SAV : TBL_DEF);
			SEL_CHANGEABLE: tableFor = TBL_CHG;
			SEL_DEFAULT:    tableFor = TBL_DEF;
			SEL_SAVED:      tableFor = savOwn ? TBL_SAV : TBL_DEF;
		endcase
	endfunction : tableFor

	// page code to table index; bit 4 flags a supported code
	function automatic logic [4:0] pageLookup(input logic [5:0] code);
		pageLookup = 5'h00;
		for (int i = 0; i < PAGE_COUNT; i++) begin
			if (PAGE_CODE[i] == code) begin
				pageLookup = {1'b1, 4'(i)};
			end
		end
	endfunction : pageLookup

	state_t      state_q, state_d;
	logic [1:0]  sel_q;
	logic [5:0]  code_q;
	logic [15:0] alloc_q;
	logic [6:0]  pos_q;
	logic [7:0]  byte_q;
	logic        done_q, check_q, lastCheck_q;
	logic [11:0] savable_q, pendOwn_q, curOwn_q, savOwn_q;
	logic [23:0] blkCnt_q, blkLen_q;
	logic [31:0] prdata_q;
	logic        copyReq_q, copyBusy_q, cpWr_q;
	logic [6:0]  cpCnt_q;
	logic [8:0]  cpWrAddr_q;

	// command decode
	wire        opcodeHit = cdb[79:72] == OPCODE_SENSE_EXT;
	wire [4:0]  lookup    = pageLookup(code_q);
	wire        allPages  = code_q == CODE_ALL_PAGES;
	wire        legal     = lookup[4] | allPages;
	wire [6:0]  total     = allPages ? RESP_ALL_LEN : RESP_ONE_LEN;
	wire [6:0]  xfer      = (alloc_q < {9'h000, total}) ?
		alloc_q[6:0] : total;
	wire        copyAny   = copyReq_q | copyBusy_q | cpWr_q;

	// position of the current byte inside the page area
	wire [6:0]  pagePos   = pos_q - HDR_DESC_LEN;
	wire        inHeader  = pos_q < HDR_DESC_LEN;
	wire [3:0]  pgIdx     = allPages ? pagePos[6:3] : lookup[3:0];
	wire [2:0]  inPg      = pagePos[2:0];
	wire [2:0]  paramIdx  = inPg - 3'h2;
	wire [1:0]  rdTbl     = tableFor(sel_q, curOwn_q[pgIdx],
		savOwn_q[pgIdx]);

	// header and descriptor bytes
	logic [7:0] hdrByte;
	always_comb begin
		unique case (pos_q[3:0])
			4'h1:    hdrByte = {1'b0, total - 7'h02};
			4'h7:    hdrByte = DESC_LEN;
			4'h9:    hdrByte = blkCnt_q[23:16];
			4'ha:    hdrByte = blkCnt_q[15:8];
			4'hb:    hdrByte = blkCnt_q[7:0];
			4'hd:    hdrByte = blkLen_q[23:16];
			4'he:    hdrByte = blkLen_q[15:8];
			4'hf:    hdrByte = blkLen_q[7:0];
			default: hdrByte = 8'h00;
		endcase
	end

	// page bytes: code byte, length byte, then table contents
	wire [7:0]  pgCode  = {savable_q[pgIdx], 1'b0,
		PAGE_CODE[pgIdx]};
	wire [7:0]  pgByte  = (inPg == 3'h0) ? pgCode :
		(inPg == 3'h1) ? PAGE_PARAM_LEN :
		tbl.rdData;
	wire [7:0]  nextByte = inHeader ? hdrByte : pgByte;

	// memory port: copy engine owns it while running
	wire        cpRdOk = cpCnt_q[6:3] < 4'd12 && cpCnt_q[2:0] < 3'd6 &&
		curOwn_q[cpCnt_q[6:3]];
	wire        apbAcc  = psel & penable;
	wire        memWrHit = apbAcc & pwrite & paddr == OFS_MEMWR;
	wire [1:0]  mwTbl   = pwdata[MW_TBL_LSB +: 2];
	wire [3:0]  mwPage  = pwdata[MW_PAGE_LSB +: 4];
	wire [2:0]  mwByte  = pwdata[MW_BYTE_LSB +: 3];
	wire        mwBad   = mwTbl == TBL_SAV || mwPage >= 4'd12 ||
		mwByte >= 3'd6;
	assign tbl.rdAddr = copyBusy_q ? {TBL_CUR, cpCnt_q} :
		{rdTbl, pgIdx, paramIdx};
	assign tbl.wrEn   = cpWr_q | (memWrHit & pready & ~mwBad);
	assign tbl.wrAddr = cpWr_q ? cpWrAddr_q : {mwTbl, mwPage, mwByte};
	assign tbl.wrData = cpWr_q ? tbl.rdData : pwdata[7:0];

	// apb: only a table write waits, and only while a copy runs
	wire        known   = paddr == OFS_CTRL || paddr == OFS_STATUS ||
		paddr == OFS_MEMWR || paddr == OFS_SAVABLE ||
		paddr == OFS_BLKCNT || paddr == OFS_BLKLEN;
	assign pready  = ~(memWrHit & (copyBusy_q | cpWr_q));
	assign pslverr = apbAcc & (~known | (memWrHit & mwBad));
	assign prdata  = prdata_q;
	wire        wrTake  = apbAcc & pwrite & pready & known;
	wire        commit  = wrTake & paddr == OFS_CTRL &
		pwdata[CTRL_COMMIT_BIT];

	logic [31:0] rdMux;
	always_comb begin
		unique case (paddr)
			OFS_STATUS:  rdMux = {4'h0, savOwn_q, curOwn_q, 1'b0,
				lastCheck_q, copyAny, state_q != ST_IDLE};
			OFS_SAVABLE: rdMux = {20'h00000, savable_q};
			OFS_BLKCNT:  rdMux = {8'h00, blkCnt_q};
			OFS_BLKLEN:  rdMux = {8'h00, blkLen_q};
			default:     rdMux = 32'h00000000;
		endcase
	end

	// read data is captured in the setup phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= 32'h00000000;
		end else if (psel & ~penable) begin
			prdata_q <= rdMux;
		end
	end

	// software-visible settings
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			savable_q <= RST_SAVABLE;
			blkCnt_q  <= RST_BLKCNT;
			blkLen_q  <= RST_BLKLEN;
		end else if (wrTake) begin
			if (paddr == OFS_SAVABLE) savable_q <= pwdata[11:0];
			if (paddr == OFS_BLKCNT)  blkCnt_q  <= pwdata[23:0];
			if (paddr == OFS_BLKLEN)  blkLen_q  <= pwdata[23:0];
		end
	end

	// page ownership: staged writes become current at commit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pendOwn_q <= 12'h000;
			curOwn_q  <= 12'h000;
			savOwn_q  <= 12'h000;
		end else begin
			if (commit) begin
				curOwn_q  <= curOwn_q | pendOwn_q;
				pendOwn_q <= 12'h000;
			end else if (memWrHit & pready & ~mwBad & mwTbl == TBL_CUR) begin
				pendOwn_q[mwPage] <= 1'b1;
			end
			if (copyBusy_q && cpCnt_q == COPY_LAST) begin
				savOwn_q <= savOwn_q | curOwn_q;
			end
		end
	end

	// save copy: waits for an idle responder so reads never clash
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			copyReq_q  <= 1'b0;
			copyBusy_q <= 1'b0;
			cpCnt_q    <= 7'h00;
			cpWr_q     <= 1'b0;
			cpWrAddr_q <= 9'h000;
		end else begin
			cpWr_q     <= copyBusy_q & cpRdOk;
			cpWrAddr_q <= {TBL_SAV, cpCnt_q};
			if (commit & pwdata[CTRL_SAVE_BIT]) begin
				copyReq_q <= 1'b1;
			end else if (copyReq_q && state_q == ST_IDLE && !cdbValid) begin
				copyReq_q  <= 1'b0;
				copyBusy_q <= 1'b1;
				cpCnt_q    <= 7'h00;
			end
			if (copyBusy_q) begin
				cpCnt_q <= cpCnt_q + 7'h01;
				if (cpCnt_q == COPY_LAST) copyBusy_q <= 1'b0;
			end
		end
	end

	// command sequencer
	assign cdbReady = state_q == ST_IDLE;
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE:   if (cdbValid && opcodeHit) state_d = ST_CHECK;
			ST_CHECK:  if (!copyAny) begin
				if (!legal || alloc_q == 16'h0000) state_d = ST_FINISH;
				else state_d = ST_FETCH;
			end
			ST_FETCH:  state_d = ST_LOAD;
			ST_LOAD:   state_d = ST_SEND;
			ST_SEND:   if (dataReady) begin
				state_d = (pos_q + 7'h01 == xfer) ? ST_FINISH : ST_FETCH;
			end
			ST_FINISH: state_d = ST_IDLE;
			default:   state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// command fields are held for the whole command
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_q   <= SEL_CURRENT;
			code_q  <= 6'h00;
			alloc_q <= 16'h0000;
		end else if (state_q == ST_IDLE && cdbValid && opcodeHit) begin
			sel_q   <= cdb[63:62];
			code_q  <= cdb[61:56];
			alloc_q <= cdb[23:8];
		end
	end

	// byte position and outgoing byte register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_q  <= 7'h00;
			byte_q <= 8'h00;
		end else begin
			if (state_q == ST_CHECK) pos_q <= 7'h00;
			else if (state_q == ST_SEND && dataReady) pos_q <= pos_q + 7'h01;
			if (state_q == ST_LOAD) byte_q <= nextByte;
		end
	end

	// completion pulse; check flag stands with it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q      <= 1'b0;
			check_q     <= 1'b0;
			lastCheck_q <= 1'b0;
		end else begin
			done_q  <= state_q == ST_FINISH;
			check_q <= state_q == ST_FINISH && !legal;
			if (state_q == ST_FINISH) lastCheck_q <= !legal;
		end
	end

	assign dataByte  = byte_q;
	assign dataValid = state_q == ST_SEND;
	assign cmdDone   = done_q;
	assign cmdCheck  = check_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence finishSeq;
		(state_q == ST_FINISH) ##1 (cmdDone && !dataValid);
	endsequence

	chk_opcode_taken: assert property (
		state_q == ST_IDLE && cdbValid && opcodeHit |=> state_q == ST_CHECK)
		else $error("matching opcode not taken");
	chk_opcode_other: assert property (
		state_q == ST_IDLE && cdbValid && !opcodeHit |=> state_q == ST_IDLE)
		else $error("foreign opcode started a command");
	chk_current_table: assert property (
		state_q == ST_FETCH && sel_q == SEL_CURRENT && !curOwn_q[pgIdx]
		|-> tbl.rdAddr[8:7] == (savOwn_q[pgIdx] ? TBL_SAV : TBL_DEF))
		else $error("current values not taken from saved view");
	chk_saved_table: assert property (
		state_q == ST_FETCH && sel_q == SEL_SAVED
		|-> tbl.rdAddr[8:7] == (savOwn_q[pgIdx] ? TBL_SAV : TBL_DEF))
		else $error("saved values from wrong table");
	chk_zero_alloc: assert property (
		state_q == ST_CHECK && !copyAny && legal && alloc_q == 16'h0000
		|=> finishSeq)
		else $error("zero allocation sent data");
	chk_illegal_check: assert property (
		state_q == ST_CHECK && !copyAny && !legal
		|=> ##1 (cmdDone && cmdCheck))
		else $error("bad page code not reported");
	chk_byte_count: assert property (
		state_q == ST_SEND && dataReady && pos_q + 7'h01 == xfer
		|=> finishSeq)
		else $error("transfer did not end at limit");
	chk_data_length: assert property (
		dataValid && pos_q == 7'h01 |-> dataByte == {1'b0, total - 7'h02})
		else $error("mode data length wrong");
	chk_desc_len: assert property (
		dataValid && pos_q == 7'h07 |-> dataByte == DESC_LEN)
		else $error("descriptor length wrong");
	chk_page_len: assert property (
		dataValid && !inHeader && inPg == 3'h1 |-> dataByte == PAGE_PARAM_LEN)
		else $error("page length byte wrong");
	chk_data_hold: assert property (
		dataValid && !dataReady |=> dataValid && $stable(dataByte))
		else $error("byte changed while stalled");
	chk_header_zero: assert property (
		dataValid && pos_q inside {7'h00, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06,
		7'h08, 7'h0c} |-> dataByte == 8'h00)
		else $error("reserved header byte not zero");
	chk_page_bit6: assert property (
		dataValid && !inHeader && inPg == 3'h0 |-> !dataByte[6])
		else $error("page code byte bit 6 set");
endmodule : mode_sense_ext_responder

/* File: testbench/initiator_model.sv */
// Purpose: initiator side of the command block and data-in stream
// Assumes: one command at a time, started by the bench through run
// Notes:   slow mode stalls dataReady on every other cycle
`timescale 1ns/1ns
module initiator_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// command block
	output logic             cdbValid,
	output logic      [79:0] cdb,
	input  wire logic        cdbReady,
	// data-in stream
	input  wire logic [7:0]  dataByte,
	input  wire logic        dataValid,
	output logic             dataReady,
	// completion
	input  wire logic        cmdDone,
	input  wire logic        cmdCheck
);
	logic [7:0] rx [$];
	logic       gotCheck;
	logic       slow;

	// quiet lines until the first command
	initial begin
		cdbValid = 1'b0;
		cdb = 80'h0;
		dataReady = 1'b0;
		slow = 1'b0;
		gotCheck = 1'b0;
	end

	// take bytes at the edge; a slow initiator stalls every other cycle
	always @(posedge clk) begin
		if (rst_n && dataValid && dataReady)
			rx.push_back(dataByte);
		dataReady <= slow ? ~dataReady : 1'b1;
	end

	// offer one block, hold it until taken, collect until completion
	task automatic run(input logic [1:0] sel, input logic [5:0] code,
		input logic [15:0] alloc, input logic slw);
		logic [79:0] blk;
		blk = {8'h5a, 8'h00, sel, code, 32'h0, alloc, 8'h00};
		rx.delete();
		slow <= slw;
		cdbValid <= 1'b1;
		cdb <= blk;
		do @(posedge clk); while (cdbReady !== 1'b1);
		cdbValid <= 1'b0;
		cdb <= ~blk; // a released block must not keep showing old bits
		do @(posedge clk); while (cmdDone !== 1'b1);
		gotCheck = cmdCheck;
	endtask : run
endmodule : initiator_model

/* File: testbench/tb_mode_sense_ext_responder.sv */
// Purpose: self-checking bench for the extended mode-sense responder
// Assumes: tables loaded over apb before any sense command
// Notes:   expected bytes come from a shadow copy of the four tables
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin nFail++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_mode_sense_ext_responder import mse_pkg::*;;
	logic        clk = 1'b0;
	logic        rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, dataByte;
	logic [31:0] pwdata, prdata, lfsr = 32'h65c77477;
	logic        cdbValid, cdbReady, dataValid, dataReady, cmdDone, cmdCheck;
	logic [79:0] cdb;
	logic [7:0]  tbl [0:3][0:11][0:5]; // cur, chg, def, saved shadow
	logic [23:0] blkCnt, blkLen;
	logic [11:0] savable;
	int          nFail = 0, checks = 0;

	// 50 MHz clock
	always #10 clk = ~clk;

	mode_sense_ext_responder dut (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cdbValid(cdbValid), .cdb(cdb),
		.cdbReady(cdbReady), .dataByte(dataByte), .dataValid(dataValid),
		.dataReady(dataReady), .cmdDone(cmdDone), .cmdCheck(cmdCheck));
	initiator_model m (.clk(clk), .rst_n(rst_n), .cdbValid(cdbValid),
		.cdb(cdb), .cdbReady(cdbReady), .dataByte(dataByte),
		.dataValid(dataValid), .dataReady(dataReady), .cmdDone(cmdDone),
		.cmdCheck(cmdCheck));

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd

	// expected response byte i; selector encodings match table numbers
	function automatic logic [7:0] expB(input int i, input logic [1:0] sel,
		input int pg, input logic all);
		int k, b;
		k = all ? (i - 16) / 8 : pg;
		b = (i - 16) % 8;
		if (i == 1) return 8'(all ? 110 : 22);
		if (i == 7) return DESC_LEN;
		if (i >= 9 && i <= 11) return blkCnt[8*(11-i) +: 8];
		if (i >= 13 && i <= 15) return blkLen[8*(15-i) +: 8];
		if (i < 16) return 8'h00;
		if (b == 0) return {savable[k], 1'b0, PAGE_CODE[k]};
		if (b == 1) return PAGE_PARAM_LEN;
		return tbl[sel][k][b-2];
	endfunction : expB

	// one apb transfer, held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// one parameter byte into a table
	task automatic mw(input logic [1:0] t, input int p, input int b,
		input logic [7:0] v);
		logic [31:0] r;
		logic        e;
		apb(1'b1, OFS_MEMWR, 32'(v) | (32'(b) << MW_BYTE_LSB) |
			(32'(p) << MW_PAGE_LSB) | (32'(t) << MW_TBL_LSB), r, e);
		`CHK("memwr err", 1'b0, e)
	endtask : mw

	// run one command and compare every returned byte
	task automatic sense(input logic [1:0] sel, input logic [5:0] code,
		input int pg, input int alloc, input logic slw);
		int n, tot;
		tot = (code == CODE_ALL_PAGES) ? 112 : 24;
		n = (pg < 0) ? 0 : ((alloc < tot) ? alloc : tot);
		m.run(sel, code, 16'(alloc), slw);
		`CHK("check", pg < 0, m.gotCheck)
		`CHK("count", n, m.rx.size())
		for (int i = 0; i < n && i < m.rx.size(); i++)
			`CHK("byte", expB(i, sel, pg, tot == 112), m.rx[i])
		$display("test sense sel %0d code %h alloc %0d done", sel, code, alloc);
	endtask : sense

	// commit staged pages, then wait until busy and copy clear
	// a save also sends a table write that must wait out the copy
	task automatic commit(input logic save, input int pg);
		logic [31:0] r;
		logic        e;
		apb(1'b1, OFS_CTRL, {30'h0, save, 1'b1}, r, e);
		if (save) begin
			tbl[1][pg][0] = 8'(rnd());
			mw(TBL_CHG, pg, 0, tbl[1][pg][0]);
		end
		do apb(1'b0, OFS_STATUS, 32'h0, r, e); while (r[1:0] !== 2'b00);
	endtask : commit

	task automatic wrapUp;
		$display("checks %0d mismatches %0d", checks, nFail);
		if (nFail == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrapUp

	// watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		nFail++;
		$display("BAD watchdog exp finish got timeout");
		wrapUp;
	end

	// main sequence
	initial begin
		logic [31:0] r;
		logic        e;
		int          p;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, OFS_SAVABLE, 32'h0, r, e);
		`CHK("savable reset", 32'(RST_SAVABLE), r)
		apb(1'b0, OFS_BLKLEN, 32'h0, r, e);
		`CHK("blklen reset", 32'(RST_BLKLEN), r)
		apb(1'b0, 8'h18, 32'h0, r, e);
		`CHK("unmapped err", 1'b1, e)
		apb(1'b1, OFS_MEMWR, 32'h3 << MW_TBL_LSB, r, e);
		`CHK("table3 err", 1'b1, e)
		apb(1'b1, OFS_MEMWR, 32'hc << MW_PAGE_LSB, r, e);
		`CHK("page12 err", 1'b1, e)
		blkCnt = 24'(rnd());
		blkLen = 24'(rnd());
		savable = 12'(rnd());
		apb(1'b1, OFS_BLKCNT, 32'(blkCnt), r, e);
		apb(1'b1, OFS_BLKLEN, 32'(blkLen), r, e);
		apb(1'b1, OFS_SAVABLE, 32'(savable), r, e);
		apb(1'b0, OFS_BLKCNT, 32'h0, r, e);
		`CHK("blkcnt", 32'(blkCnt), r)
		$display("test registers done");
		// changeable and default tables; current and saved start at default
		for (int t = 1; t <= 2; t++)
			for (int pg = 0; pg < 12; pg++)
				for (int b = 0; b < 6; b++) begin
					tbl[t][pg][b] = rnd();
					mw(2'(t), pg, b, tbl[t][pg][b]);
				end
		tbl[0] = tbl[2];
		tbl[3] = tbl[2];
		for (int s = 0; s < 4; s++) begin
			p = rnd() % 12;
			sense(2'(s), PAGE_CODE[p], p, 8 + rnd() % 24, s[0]);
		end
		sense(SEL_CURRENT, CODE_ALL_PAGES, 0, 255, 1'b1);
		sense(SEL_DEFAULT, CODE_ALL_PAGES, 0, 50, 1'b0);
		sense(SEL_CURRENT, 6'h05, -1, 100, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0, r, e);
		`CHK("last check", 1'b1, r[2])
		sense(SEL_CHANGEABLE, PAGE_CODE[3], 3, 0, 1'b0);
		// select with save, then a second one without
		p = rnd() % 12;
		for (int k = 0; k < 2; k++) begin
			// stage exactly as many bytes as the reported page length
			for (int b = 0; b < int'(PAGE_PARAM_LEN); b++) begin
				tbl[0][(p+k)%12][b] = rnd();
				mw(TBL_CUR, (p + k) % 12, b, tbl[0][(p+k)%12][b]);
			end
			commit(k == 0, p);
			if (k == 0)
				tbl[3][p] = tbl[0][p];
		end
		apb(1'b0, OFS_STATUS, 32'h0, r, e);
		`CHK("cur owned", 12'((1 << p) | (1 << ((p + 1) % 12))), r[15:4])
		`CHK("saved owned", 12'(1 << p), r[27:16])
		sense(SEL_CURRENT, CODE_ALL_PAGES, 0, 255, 1'b0);
		sense(SEL_SAVED, CODE_ALL_PAGES, 0, 255, 1'b1);
		sense(SEL_CHANGEABLE, PAGE_CODE[p], p, 24, 1'b0);
		wrapUp;
	end
endmodule : tb_mode_sense_ext_responder
